// ---- design/mcrb_map.vh ----
`ifndef MCRB_MAP_VH
`define MCRB_MAP_VH
// ----------------------------------------
// Port register addresses
// ----------------------------------------
`define MCRB_ADDR_DLDIR 4'h5
`define MCRB_ADDR_P6DIR 4'h6
`define MCRB_ADDR_P7DIR 4'h7
`define MCRB_ADDR_SINK 4'h8
`define MCRB_ADDR_MODE 4'ha
`define MCRB_ADDR_P6PL 4'hb
`define MCRB_ADDR_P6PH 4'hc
`define MCRB_ADDR_P7PH 4'hd
`define MCRB_ADDR_SFC 4'he
`define MCRB_ADDR_IMASK 4'hf
// ----------------------------------------
// Reset values
// ----------------------------------------
`define MCRB_RST_STATUS 8'h00
`define MCRB_RST_CTRL 8'h00
`define MCRB_RST_DLDIR 8'h03
`define MCRB_RST_P6DIR 8'hff
`define MCRB_RST_P7DIR 8'h0f
`define MCRB_RST_SINK 8'h00
`define MCRB_RST_MODE 8'hc3
`define MCRB_RST_P6PL 8'h00
`define MCRB_RST_P6PH 8'h00
`define MCRB_RST_P7PH 8'h00
`define MCRB_RST_SFC 8'hf0
`define MCRB_RST_IMASK 8'h00
// ----------------------------------------
// Field positions and masks
// ----------------------------------------
`define MCRB_CTRL_WDPS_LSB 0
`define MCRB_CTRL_TMPS_LSB 3
`define MCRB_CTRL_INTDIS 6
`define MCRB_CTRL_RWAKE 7
`define MCRB_SFC_RUN 4
`define MCRB_SFC_WDEN 5
`define MCRB_SFC_WAKEDIS 6
`define MCRB_SFC_DUAL 7
`define MCRB_MODE_PS2 2'b10
`define MCRB_MASK_DLDIR 8'h03
`define MCRB_MASK_P7 8'h0f
`define MCRB_MASK_SINK 8'h33
`define MCRB_MASK_MODE 8'hc3
`define MCRB_MASK_SFC 8'hf0
`define MCRB_MASK_IMASK 8'h3f
// ----------------------------------------
// Timing: 6 MHz timer source, watchdog base
// ----------------------------------------
`define MCRB_CLK_HZ 25000000
`define MCRB_TMR_SRC_HZ 6000000
`define MCRB_TMR_BASE_CYC (`MCRB_CLK_HZ / `MCRB_TMR_SRC_HZ)
`define MCRB_WD_BASE_MS 8
`define MCRB_WD_BASE_CYC (`MCRB_CLK_HZ / 1000 * `MCRB_WD_BASE_MS)
`endif

// ---- design/mcrb_bank.v ----
`timescale 1ns/1ns
`include "mcrb_map.vh"
module mcrb_bank (
    // ----------------------------------------
    // Clock and reset
    // ----------------------------------------
    input wire clk,
    input wire rst_n,
    // ----------------------------------------
    // Instruction strobes and data bus
    // ----------------------------------------
    input wire control_read_instr,
    input wire control_write_instr,
    input wire port_register_read_instr,
    input wire port_register_write_instr,
    input wire status_write,
    input wire [3:0] port_addr,
    input wire [7:0] wr_data,
    output reg [7:0] rd_data_ff,
    input wire disable_interrupts_instr,
    input wire enable_interrupts_instr,
    input wire return_from_interrupt_instr,
    output wire [7:0] status_rd,
    // ----------------------------------------
    // General-purpose RAM
    // ----------------------------------------
    input wire ram_we,
    input wire [5:0] ram_addr,
    input wire bank_select,
    input wire [7:0] ram_wdata,
    output reg [7:0] ram_rdata_ff,
    // ----------------------------------------
    // Hardware events
    // ----------------------------------------
    input wire usb_setup_vendor,
    input wire usb_suspend_det,
    input wire usb_reset_det,
    input wire usb_suspend_level,
    input wire [1:0] data_line_pin,
    input wire wake_signal,
    input wire set_feature_rwake,
    input wire clear_feature_rwake,
    // ----------------------------------------
    // Control outputs
    // ----------------------------------------
    output wire irq,
    output wire watchdog_timeout,
    output wire [1:0] data_line_input,
    output wire [7:0] port6_input,
    output wire [3:0] port7_input,
    output wire [1:0] sink0_level_sel,
    output wire [1:0] sink1_level_sel,
    output wire [1:0] op_mode,
    output wire [1:0] slow_freq_sel,
    output wire [7:0] port6_pulldown_bit,
    output wire [7:0] port6_pullup_bit,
    output wire [3:0] port7_pullup_bit,
    output wire clock_run,
    output wire slow_clock_sel,
    output wire usb_ctrl_halt,
    output wire wake_on_change_disable,
    output wire watchdog_enable_bit,
    output wire [7:0] timer_counter
);

// ----------------------------------------
// Registers
// ----------------------------------------
reg [7:0] status_ff;
reg [7:0] nxt_status;
reg [7:0] ctrl_ff;
reg [7:0] dldir_ff;
reg [7:0] p6dir_ff;
reg [7:0] p7dir_ff;
reg [7:0] sink_ff;
reg [7:0] mode_ff;
reg [7:0] p6pl_ff;
reg [7:0] p6ph_ff;
reg [7:0] p7ph_ff;
reg [7:0] sfc_ff;
reg [7:0] imask_ff;
reg [7:0] ram_ff [0:79];
reg [1:0] dl_s1_ff;
reg [1:0] dl_s2_ff;
reg [1:0] dl_s3_ff;
reg [2:0] susp_s_ff;
reg [2:0] wake_s_ff;
reg [7:0] pre_ff;
reg [7:0] tmr_ff;
reg [4:0] base_ff;
reg [31:0] wd_ff;
reg [7:0] port_rd;
reg [6:0] ram_idx;
wire port_wr;
wire tick;
wire tmr_ovf;
wire [7:0] pre_mask;
wire [31:0] wd_limit;
wire [7:0] set_ev;
wire [15:0] pre_wide;

// ----------------------------------------
// Counts kept at 32 bits, trimmed where compared
// ----------------------------------------
localparam [31:0] tmr_base_last = `MCRB_TMR_BASE_CYC - 1;
localparam [31:0] wd_base = `MCRB_WD_BASE_CYC;

assign port_wr = port_register_write_instr;

// ----------------------------------------
// Synchronisers for pin-side inputs
// ----------------------------------------
always @(posedge clk) begin
    if (!rst_n) begin
        dl_s1_ff <= 2'h0;
        dl_s2_ff <= 2'h0;
        dl_s3_ff <= 2'h0;
        susp_s_ff <= 3'h0;
        wake_s_ff <= 3'h0;
    end else begin
        dl_s1_ff <= data_line_pin;
        dl_s2_ff <= dl_s1_ff;
        dl_s3_ff <= dl_s2_ff;
        susp_s_ff <= {susp_s_ff[1:0], usb_suspend_level};
        wake_s_ff <= {wake_s_ff[1:0], wake_signal};
    end
end

// ----------------------------------------
// Timer counter with prescaler
// ----------------------------------------
// Timer source approximated as clk / 4; 25 MHz is not a multiple of 6 MHz
assign tick = (base_ff == tmr_base_last[4:0]);
// Span is 2 to 256 ticks; code 7 needs the ninth bit before the minus one
assign pre_wide = (16'h2 << ctrl_ff[5:3]) - 16'h1;
assign pre_mask = pre_wide[7:0];
assign tmr_ovf = tick && ((pre_ff & pre_mask) == pre_mask) && (tmr_ff == 8'hff);
assign timer_counter = tmr_ff;

always @(posedge clk) begin
    if (!rst_n) begin
        base_ff <= 5'h0;
        pre_ff <= 8'h0;
        tmr_ff <= 8'h0;
    end else if (clock_run) begin
        base_ff <= tick ? 5'h0 : base_ff + 5'h1;
        if (tick) begin
            pre_ff <= ((pre_ff & pre_mask) == pre_mask) ? 8'h0 : pre_ff + 8'h1;
            if ((pre_ff & pre_mask) == pre_mask) begin
                tmr_ff <= tmr_ff + 8'h1;
            end
        end
    end
end

// ----------------------------------------
// Watchdog
// ----------------------------------------
// Count restarts on timeout, so the timeout pulse lasts one cycle
assign wd_limit = wd_base << ctrl_ff[2:0];
assign watchdog_timeout = watchdog_enable_bit && (wd_ff == wd_limit - 32'h1);

always @(posedge clk) begin
    if (!rst_n) begin
        wd_ff <= 32'h0;
    end else if (!watchdog_enable_bit || watchdog_timeout) begin
        wd_ff <= 32'h0;
    end else begin
        wd_ff <= wd_ff + 32'h1;
    end
end

// ----------------------------------------
// Interrupt status flags
// ----------------------------------------
assign set_ev[0] = tmr_ovf;
assign set_ev[1] = usb_setup_vendor;
assign set_ev[2] = usb_suspend_det;
assign set_ev[3] = usb_reset_det;
assign set_ev[4] = slow_clock_sel && susp_s_ff[2] && !susp_s_ff[1];
assign set_ev[5] = (op_mode == `MCRB_MODE_PS2) && (dl_s3_ff != dl_s2_ff);
assign set_ev[7:6] = 2'h0;

always @* begin
    nxt_status = status_ff;
    if (status_write) begin
        nxt_status = status_ff & wr_data & 8'h3f;
    end
    nxt_status = nxt_status | set_ev;
end

always @(posedge clk) begin
    if (!rst_n) begin
        status_ff <= `MCRB_RST_STATUS;
    end else begin
        status_ff <= nxt_status;
    end
end

assign status_rd = status_ff;
assign irq = |(status_ff & imask_ff) && !ctrl_ff[`MCRB_CTRL_INTDIS];

// ----------------------------------------
// Control register
// ----------------------------------------
always @(posedge clk) begin
    if (!rst_n) begin
        ctrl_ff <= `MCRB_RST_CTRL;
    end else begin
        if (control_write_instr) begin
            ctrl_ff <= wr_data;
        end
        if (disable_interrupts_instr) begin
            ctrl_ff[`MCRB_CTRL_INTDIS] <= 1'b1;
        end else if (enable_interrupts_instr || return_from_interrupt_instr) begin
            ctrl_ff[`MCRB_CTRL_INTDIS] <= 1'b0;
        end
        if (set_feature_rwake) begin
            ctrl_ff[`MCRB_CTRL_RWAKE] <= 1'b1;
        end else if (clear_feature_rwake) begin
            ctrl_ff[`MCRB_CTRL_RWAKE] <= 1'b0;
        end
    end
end

// ----------------------------------------
// Port control registers
// ----------------------------------------
always @(posedge clk) begin
    if (!rst_n) begin
        dldir_ff <= `MCRB_RST_DLDIR;
        p6dir_ff <= `MCRB_RST_P6DIR;
        p7dir_ff <= `MCRB_RST_P7DIR;
        sink_ff <= `MCRB_RST_SINK;
        mode_ff <= `MCRB_RST_MODE;
        p6pl_ff <= `MCRB_RST_P6PL;
        p6ph_ff <= `MCRB_RST_P6PH;
        p7ph_ff <= `MCRB_RST_P7PH;
        sfc_ff <= `MCRB_RST_SFC;
        imask_ff <= `MCRB_RST_IMASK;
    end else begin
        if (port_wr && port_addr == `MCRB_ADDR_DLDIR) begin
            dldir_ff <= wr_data & `MCRB_MASK_DLDIR;
        end else if (port_wr && port_addr == `MCRB_ADDR_P6DIR) begin
            p6dir_ff <= wr_data;
        end else if (port_wr && port_addr == `MCRB_ADDR_P7DIR) begin
            p7dir_ff <= wr_data & `MCRB_MASK_P7;
        end else if (port_wr && port_addr == `MCRB_ADDR_SINK) begin
            sink_ff <= wr_data & `MCRB_MASK_SINK;
        end else if (port_wr && port_addr == `MCRB_ADDR_MODE) begin
            mode_ff <= wr_data & `MCRB_MASK_MODE;
        end else if (port_wr && port_addr == `MCRB_ADDR_P6PL) begin
            p6pl_ff <= wr_data;
        end else if (port_wr && port_addr == `MCRB_ADDR_P6PH) begin
            p6ph_ff <= wr_data;
        end else if (port_wr && port_addr == `MCRB_ADDR_P7PH) begin
            p7ph_ff <= wr_data & `MCRB_MASK_P7;
        end else if (port_wr && port_addr == `MCRB_ADDR_IMASK) begin
            imask_ff <= wr_data & `MCRB_MASK_IMASK;
        end
        // Wake edge beats a same-cycle firmware clear of the run bit
        if (port_wr && port_addr == `MCRB_ADDR_SFC) begin
            sfc_ff <= wr_data & `MCRB_MASK_SFC;
        end
        if (wake_s_ff[2] && !wake_s_ff[1]) begin
            sfc_ff[`MCRB_SFC_RUN] <= 1'b1;
        end
    end
end

// ----------------------------------------
// Read paths
// ----------------------------------------
always @* begin
    if (port_addr == `MCRB_ADDR_DLDIR) begin
        port_rd = dldir_ff;
    end else if (port_addr == `MCRB_ADDR_P6DIR) begin
        port_rd = p6dir_ff;
    end else if (port_addr == `MCRB_ADDR_P7DIR) begin
        port_rd = p7dir_ff;
    end else if (port_addr == `MCRB_ADDR_SINK) begin
        port_rd = sink_ff;
    end else if (port_addr == `MCRB_ADDR_MODE) begin
        port_rd = mode_ff;
    end else if (port_addr == `MCRB_ADDR_P6PL) begin
        port_rd = p6pl_ff;
    end else if (port_addr == `MCRB_ADDR_P6PH) begin
        port_rd = p6ph_ff;
    end else if (port_addr == `MCRB_ADDR_P7PH) begin
        port_rd = p7ph_ff;
    end else if (port_addr == `MCRB_ADDR_SFC) begin
        port_rd = sfc_ff;
    end else if (port_addr == `MCRB_ADDR_IMASK) begin
        port_rd = imask_ff;
    end else begin
        port_rd = 8'h00;
    end
end

always @(posedge clk) begin
    if (!rst_n) begin
        rd_data_ff <= 8'h00;
    end else if (control_read_instr) begin
        rd_data_ff <= ctrl_ff;
    end else if (port_register_read_instr) begin
        rd_data_ff <= port_rd;
    end
end

// ----------------------------------------
// General-purpose RAM: 16 shared plus two banks of 32
// ----------------------------------------
always @* begin
    if (ram_addr[5]) begin
        // Bank 1 sits right after bank 0, above the shared 16 bytes
        ram_idx = {1'b0, bank_select, 5'h0} + {2'h0, ram_addr[4:0]} + 7'h10;
    end else begin
        ram_idx = {3'h0, ram_addr[3:0]};
    end
end

always @(posedge clk) begin
    if (ram_we && ram_addr[5:4] != 2'h0) begin
        ram_ff[ram_idx] <= ram_wdata;
    end
    ram_rdata_ff <= ram_ff[ram_idx];
end

// ----------------------------------------
// Pin and clock controls
// ----------------------------------------
assign data_line_input = dldir_ff[1:0];
assign port6_input = p6dir_ff;
assign port7_input = p7dir_ff[3:0];
assign sink0_level_sel = sink_ff[1:0];
assign sink1_level_sel = sink_ff[5:4];
assign op_mode = mode_ff[1:0];
assign slow_freq_sel = mode_ff[7:6];
assign port6_pulldown_bit = p6pl_ff;
assign port6_pullup_bit = p6ph_ff;
assign port7_pullup_bit = p7ph_ff[3:0];
assign clock_run = sfc_ff[`MCRB_SFC_RUN];
assign watchdog_enable_bit = sfc_ff[`MCRB_SFC_WDEN];
assign wake_on_change_disable = sfc_ff[`MCRB_SFC_WAKEDIS];
assign slow_clock_sel = !sfc_ff[`MCRB_SFC_DUAL];
assign usb_ctrl_halt = !sfc_ff[`MCRB_SFC_DUAL];

endmodule // mcrb_bank

// ---- verif/mcrb_chk.sv ----
`timescale 1ns/1ns
module mcrb_chk (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Strobes and data
    input wire status_write,
    input wire port_register_write_instr,
    input wire control_read_instr,
    input wire control_write_instr,
    input wire disable_interrupts_instr,
    input wire [3:0] port_addr,
    input wire [7:0] wr_data,
    input wire [7:0] rd_data_ff,
    // Events
    input wire usb_setup_vendor,
    input wire usb_suspend_det,
    input wire usb_reset_det,
    input wire wake_signal,
    input wire set_feature_rwake,
    input wire clear_feature_rwake,
    // Observed state
    input wire [7:0] status_rd,
    input wire irq,
    input wire [1:0] op_mode,
    input wire [7:0] port6_input,
    input wire clock_run,
    input wire watchdog_timeout,
    input wire watchdog_enable_bit,
    input wire [7:0] timer_counter
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Set must not be masked by a write in the same cycle
    sequence rwake_set_s;
        set_feature_rwake && !control_write_instr;
    endsequence
    sequence ctrl_read_s;
        control_read_instr && !clear_feature_rwake && !control_write_instr;
    endsequence
    sequence rwake_keep_s;
        !clear_feature_rwake && !control_write_instr;
    endsequence
    sequence wake_fall_s;
        $fell(wake_signal);
    endsequence
    // Shortest watchdog span: 8 ms at 25 MHz
    localparam int WD_MIN = 200000;
    int wd_run = 0;
    always @(posedge clk) begin
        if (!rst_n || !watchdog_enable_bit || watchdog_timeout) begin
            wd_run <= 0;
        end else begin
            wd_run <= wd_run + 1;
        end
    end
    wd_early_a: assert property (watchdog_timeout |-> wd_run >= WD_MIN - 1)
        else $error("watchdog timeout too early");
    wd_pulse_a: assert property (watchdog_timeout |=> !watchdog_timeout)
        else $error("watchdog timeout longer than one cycle");
    wd_off_a: assert property (!watchdog_enable_bit |-> !watchdog_timeout)
        else $error("watchdog timeout while disabled");
    status_hi_a: assert property (status_rd[7:6] == 2'b00)
        else $error("status high bits set");
    setup_flag_a: assert property (usb_setup_vendor |=> status_rd[1])
        else $error("endpoint flag not set");
    suspend_flag_a: assert property (usb_suspend_det |=> status_rd[2])
        else $error("suspend flag not set");
    reset_flag_a: assert property (usb_reset_det |=> status_rd[3])
        else $error("bus reset flag not set");
    flag_hold_a: assert property (status_rd[1] && !status_write |=> status_rd[1])
        else $error("endpoint flag lost");
    flag_clear_a: assert property (status_write && !wr_data[3] && !usb_reset_det
        |=> !status_rd[3]) else $error("flag not cleared");
    irq_source_a: assert property (irq |-> status_rd[5:0] != 6'h00)
        else $error("irq without flag");
    irq_block_a: assert property (disable_interrupts_instr |=> !irq)
        else $error("irq while disabled");
    rwake_read_a: assert property (rwake_set_s ##1 rwake_keep_s ##1 ctrl_read_s
        |=> rd_data_ff[7]) else $error("remote wakeup bit not set");
    wake_run_a: assert property (wake_fall_s |-> ##[1:6] clock_run)
        else $error("run bit not restored");
    timer_hold_a: assert property (!clock_run [*2] |=> $stable(timer_counter))
        else $error("timer ran while stopped");
    mode_write_a: assert property (port_register_write_instr && port_addr == 4'ha
        |=> op_mode == $past(wr_data[1:0])) else $error("mode not updated");
    dir_write_a: assert property (port_register_write_instr && port_addr == 4'h6
        |=> port6_input == $past(wr_data)) else $error("direction not updated");
endmodule // mcrb_chk

// ---- verif/testbench.sv ----
`timescale 1ns/1ns
module testbench;
    // ----------------------------------------
    // Stimulus and observation
    // ----------------------------------------
    logic clk = 0, rst_n = 0, ram_we = 0, bank_select = 0;
    logic usb_suspend_level = 1, wake_signal = 1;
    logic [4:0] st = 0;
    logic [7:0] ev = 0, wr_data = 0, ram_wdata = 0, d;
    logic [3:0] port_addr = 0;
    logic [5:0] ram_addr = 0;
    logic [1:0] data_line_pin = 0;
    wire port_register_write_instr = st[0], port_register_read_instr = st[1];
    wire control_write_instr = st[2], control_read_instr = st[3], status_write = st[4];
    wire usb_setup_vendor = ev[0], usb_suspend_det = ev[1], usb_reset_det = ev[2];
    wire set_feature_rwake = ev[3], clear_feature_rwake = ev[4];
    wire disable_interrupts_instr = ev[5], enable_interrupts_instr = ev[6];
    wire return_from_interrupt_instr = ev[7];
    wire [7:0] rd_data_ff, status_rd, ram_rdata_ff, port6_input, port6_pulldown_bit;
    wire [7:0] port6_pullup_bit, timer_counter;
    wire [3:0] port7_input, port7_pullup_bit;
    wire [1:0] data_line_input, sink0_level_sel, sink1_level_sel, op_mode, slow_freq_sel;
    wire irq, watchdog_timeout, clock_run, slow_clock_sel, usb_ctrl_halt;
    wire wake_on_change_disable, watchdog_enable_bit;
    int err_count = 0, samples_checked = 0, n;
    // Byte per port address: reset values, then writable bits
    localparam [127:0] RV = 128'h00f00000_00c30000_0fff0300_00000000;
    localparam [127:0] MK = 128'h3ff00fff_ffc30033_0fff0300_00000000;

    mcrb_bank mcrb_bank_i (.*);

    always #20 clk = ~clk;

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task chk(input [31:0] g, input [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Kind: 0 port wr, 1 port rd, 2 ctrl wr, 3 ctrl rd, 4 status wr
    task acc(input [2:0] k, input [3:0] a, input [7:0] v);
        @(posedge clk);
        st <= 5'h01 << k;
        port_addr <= a;
        wr_data <= v;
        @(posedge clk);
        st <= 0;
        #1;
    endtask
    task pulse(input [7:0] m);
        @(posedge clk);
        ev <= m;
        @(posedge clk);
        ev <= 0;
        #1;
    endtask
    task ram(input w, input b, input [5:0] a, input [7:0] v);
        @(posedge clk);
        ram_we <= w;
        bank_select <= b;
        ram_addr <= a;
        ram_wdata <= v;
        @(posedge clk);
        ram_we <= 0;
        #1;
    endtask
    // Cycles between two timer steps; first loop only aligns
    task span(output int c);
        for (int i = 0; i < 2; i++) begin
            d = timer_counter;
            c = 0;
            while (timer_counter === d && c < 600) begin
                @(posedge clk);
                #1;
                c++;
            end
        end
    endtask
    task results;
        if (err_count == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1;
        for (int a = 0; a < 16; a++) begin
            acc(1, a[3:0], 0);
            chk(rd_data_ff, RV[a*8 +: 8]);
        end
        acc(3, 0, 0);
        chk({rd_data_ff, status_rd}, 0);
        for (int j = 0; j < 2; j++) begin
            d = j ? 8'h5a : 8'hff;
            for (int a = 0; a < 16; a++) acc(0, a[3:0], d);
            for (int a = 0; a < 16; a++) begin
                acc(1, a[3:0], 0);
                chk(rd_data_ff, d & MK[a*8 +: 8]);
            end
        end
        chk({port6_input, port6_pulldown_bit, port6_pullup_bit, port7_pullup_bit,
            port7_input}, 32'h5a5a5aaa);
        chk({data_line_input, sink1_level_sel, sink0_level_sel, op_mode, slow_freq_sel,
            watchdog_enable_bit, slow_clock_sel, usb_ctrl_halt, clock_run,
            wake_on_change_disable}, 32'h4d2f);
        // Legacy mode on slow clock: every hardware flag may rise
        pulse(8'h07);
        @(posedge clk);
        data_line_pin <= 2'b01;
        usb_suspend_level <= 0;
        repeat (6) @(posedge clk);
        #1 chk(status_rd & 8'hfe, 8'h3e);
        @(posedge clk);
        st <= 5'h10;
        wr_data <= 0;
        ev <= 8'h02;
        @(posedge clk);
        st <= 0;
        ev <= 0;
        #1 chk(status_rd & 8'hfe, 8'h04);
        acc(4, 0, 8'hff);
        chk(status_rd & 8'hfe, 8'h04);
        acc(4, 0, 0);
        // USB mode, normal clock: line and resume events stay quiet
        acc(0, 4'ha, 8'h01);
        acc(0, 4'he, 8'hb0);
        @(posedge clk);
        data_line_pin <= 2'b11;
        usb_suspend_level <= 1;
        repeat (6) @(posedge clk);
        usb_suspend_level <= 0;
        repeat (6) @(posedge clk);
        #1 chk(status_rd & 8'hfe, 0);
        acc(0, 4'hf, 8'h02);
        acc(2, 0, 0);
        pulse(8'h01);
        chk(irq, 1);
        pulse(8'h20);
        chk(irq, 0);
        acc(3, 0, 0);
        chk(rd_data_ff, 8'h40);
        pulse(8'h40);
        chk(irq, 1);
        pulse(8'h20);
        pulse(8'h80);
        chk(irq, 1);
        acc(0, 4'hf, 8'h3d);
        chk(irq, 0);
        acc(4, 0, 0);
        pulse(8'h08);
        acc(3, 0, 0);
        chk(rd_data_ff, 8'h80);
        pulse(8'h10);
        acc(3, 0, 0);
        chk(rd_data_ff, 0);
        acc(2, 0, 8'hff);
        acc(3, 0, 0);
        chk(rd_data_ff, 8'hff);
        for (int k = 2; k >= 0; k--) begin
            acc(2, 0, {2'b00, k[2:0], 3'b000});
            span(n);
            chk(n, 8 << k);
        end
        acc(4, 0, 0);
        n = 0;
        while (status_rd[0] !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1 n++;
        end
        chk(status_rd[0], 1);
        acc(0, 4'he, 8'ha0);
        chk(clock_run, 0);
        repeat (10) @(posedge clk);
        wake_signal <= 0;
        repeat (6) @(posedge clk);
        #1 chk(clock_run, 1);
        acc(1, 4'he, 0);
        chk(rd_data_ff, 8'hb0);
        chk(watchdog_timeout, 0);
        // Shared low block versus banked upper block
        ram(1, 0, 6'h15, 8'h11);
        ram(0, 1, 6'h15, 0);
        chk(ram_rdata_ff, 8'h11);
        ram(1, 0, 6'h25, 8'h22);
        ram(1, 1, 6'h25, 8'h33);
        ram(0, 0, 6'h25, 0);
        chk(ram_rdata_ff, 8'h22);
        ram(0, 1, 6'h25, 0);
        chk(ram_rdata_ff, 8'h33);
        results;
    end

    // Whole sequence needs well under 10000 cycles
    initial begin
        #(40 * 30000);
        err_count++;
        results;
    end
endmodule // testbench

bind mcrb_bank mcrb_chk mcrb_chk_i (.*);
